// ### tpbs_defs.svh
`ifndef TPBS_DEFS_SVH
`define TPBS_DEFS_SVH

// =====================================================================
// Register offsets of the plain register port.
`define TPBS_ADDR_W 4
`define TPBS_OFF_CTRL 4'h0
`define TPBS_OFF_STATUS 4'h1
`define TPBS_OFF_SECURE 4'h2
`define TPBS_OFF_PROC_ID 4'h3
`define TPBS_OFF_DMA_ID 4'h4
`define TPBS_OFF_STRAP 4'h5

// =====================================================================
// Field positions.
`define TPBS_CTRL_CLR_FLAG 0
`define TPBS_CTRL_SELF_RST 1
`define TPBS_CTRL_APP_GO 2

// =====================================================================
// Reset values and identifiers.
`define TPBS_ID_W 4
`define TPBS_PROC_ID_RST 4'h0
`define TPBS_DMA_ID_RST 4'h1
`define TPBS_PROC_ID_APP 4'h8
`define TPBS_DMA_ID_APP 4'h9
`define TPBS_SECURE_RST 8'h00

// =====================================================================
// Strap encodings.
`define TPBS_STRAP_SERIAL 3'h4
`define TPBS_STRAP_TWO_WIRE 3'h1
`define TPBS_STRAP_FOUR_WIRE 3'h0

// =====================================================================
// Timing: strap sampling window and self-reset pulse length.
`define TPBS_SAMPLE_NS 40
`define TPBS_CLK_NS 4
`define TPBS_SAMPLE_CYC ((`TPBS_SAMPLE_NS + `TPBS_CLK_NS - 1) / `TPBS_CLK_NS)
`define TPBS_SELF_RST_CYC 4

`endif

// ### tpbs_pkg.sv
`default_nettype none
package tpbs_pkg;

  // =====================================================================
  // Boot phases.
  typedef enum logic [2:0] {
    TPBS_ST_POWER_UP = 3'b000,
    TPBS_ST_FIRST_ROM = 3'b001,
    TPBS_ST_INIT = 3'b010,
    TPBS_ST_SELF_RST = 3'b011,
    TPBS_ST_UNSECURE = 3'b100,
    TPBS_ST_APP = 3'b101
  } tpbs_state_t;

  // Operating modes chosen by the straps.
  typedef enum logic [1:0] {
    TPBS_MODE_FOUR_WIRE = 2'b00,
    TPBS_MODE_TWO_WIRE = 2'b01,
    TPBS_MODE_SERIAL = 2'b10
  } tpbs_mode_t;

  // Pin mapping that follows from the mode.
  typedef struct packed {
    logic debug_tdi_en;
    logic debug_tdo_en;
    logic debug_tms_en;
    logic debug_tck_en;
    logic uart0_load_en;
  } tpbs_pinmap_t;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpbs_req_t;

endpackage
`default_nettype wire

// ### tpbs_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpbs_defs.svh"

// =====================================================================
// Overview of operation
// - After power-on reset release, execution starts in the first ROM lines.
// - First ROM lines pick init or application boot from the first-boot flag.
// - Power-on reset sets the first-boot flag.
// - Secure registers accept accesses only during the init boot phase.
// - With the flag set, the init code from ROM runs.
// - Init end clears the flag and changes processor and DMA master IDs.
// - A self-reset then starts a second boot without setting the flag.
// - Second boot rereads the cleared flag and uses the unprivileged ID.
// - After first ROM lines and unsecure code, branch to application code.
// - Secure region stays locked until the next power-on reset.
// - Straps are sampled at power-up and latched as the core leaves reset.
// - Latched strap selects boot flow and default debug and UART pins.
// - Strap 3'b100 selects serial load mode.
// - Serial load mode waits forever for code and uses four-wire debug.
// - Strap 3'b001 selects two-wire debug using only TMS and TCK.
// - Strap 3'b000 selects four-wire debug using TDI, TMS, TCK, TDO.
// - Strap pin two may become an application output after power-up.
// - Strap pins zero and one stay dedicated, never general purpose.
module tpbs_sequencer
#(
  parameter int SAMPLE_CYC = `TPBS_SAMPLE_CYC,
  parameter int SELF_RST_CYC = `TPBS_SELF_RST_CYC
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [2:0] power_up_strap,
  input wire logic serial_code_loaded,
  input wire logic app_pin_two_out,
  input wire logic app_pin_two_oe,
  input wire tpbs_pkg::tpbs_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic cpu_rst,
  output logic [3:0] proc_master_id,
  output logic [3:0] dma_master_id,
  output logic secure_open,
  output logic run_app,
  output tpbs_pkg::tpbs_pinmap_t pin_map,
  output tpbs_pkg::tpbs_mode_t boot_mode,
  output logic strap_pin_two_out,
  output logic strap_pin_two_oe
);
  import tpbs_pkg::*;

  // =====================================================================
  // Strap synchroniser: three stages, a value counts once the last two stages agree.
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic strap_stable;
  assign strap_stable = (sync2_q == sync3_q);

  // Straps settle asynchronously; the first stage feeds only the second.
  always_ff @(posedge core_clk)
  begin
    if (clk_en)
    begin
      sync1_q <= power_up_strap;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // =====================================================================
  // Mode decode of the latched strap, used for boot flow and for pin mapping.
  function automatic tpbs_mode_t decode_mode(input logic [2:0] s);
    if (s == `TPBS_STRAP_SERIAL)
      decode_mode = TPBS_MODE_SERIAL;
    else if (s == `TPBS_STRAP_TWO_WIRE)
      decode_mode = TPBS_MODE_TWO_WIRE;
    else
      decode_mode = TPBS_MODE_FOUR_WIRE;
  endfunction

  function automatic tpbs_pinmap_t map_pins(input tpbs_mode_t m);
    tpbs_pinmap_t p;
    p = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    if (m == TPBS_MODE_TWO_WIRE)
      p = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    else if (m == TPBS_MODE_SERIAL)
      p = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    map_pins = p;
  endfunction

  // =====================================================================
  // Boot state, first-boot flag and secure registers.
  tpbs_state_t state_q;
  tpbs_state_t state_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic first_boot_q;
  logic [2:0] strap_q;
  logic [3:0] proc_id_q;
  logic [3:0] dma_id_q;
  logic [7:0] secure_q;
  logic strap_done_q;

  logic in_init;
  logic wr_ctrl;
  logic wr_secure;
  logic wr_proc;
  logic wr_dma;
  logic clr_flag;
  logic self_rst_req;
  logic app_go;
  logic cnt_done;
  tpbs_mode_t mode_w;

  assign in_init = (state_q == TPBS_ST_INIT);
  assign wr_ctrl = reg_req.wr && (reg_req.addr == `TPBS_OFF_CTRL);
  assign wr_secure = reg_req.wr && in_init &&
                     (reg_req.addr == `TPBS_OFF_SECURE);
  assign wr_proc = reg_req.wr && in_init &&
                   (reg_req.addr == `TPBS_OFF_PROC_ID);
  assign wr_dma = reg_req.wr && in_init &&
                  (reg_req.addr == `TPBS_OFF_DMA_ID);
  assign clr_flag = wr_ctrl && in_init &&
                    reg_req.wdata[`TPBS_CTRL_CLR_FLAG];
  assign self_rst_req = wr_ctrl && in_init && !first_boot_q &&
                        reg_req.wdata[`TPBS_CTRL_SELF_RST];
  assign app_go = wr_ctrl && (state_q == TPBS_ST_UNSECURE) &&
                  reg_req.wdata[`TPBS_CTRL_APP_GO];
  assign cnt_done = (cnt_q == 16'(SELF_RST_CYC - 1));
  assign mode_w = decode_mode(strap_q);

  // Next state of the boot sequence.
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      TPBS_ST_POWER_UP:
      begin
        // Hold the core in reset until straps have been stable long enough.
        if (!strap_stable)
          cnt_d = 16'h0000;
        else if (cnt_q == 16'(SAMPLE_CYC))
          state_d = TPBS_ST_FIRST_ROM;
        else
          cnt_d = cnt_q + 16'h0001;
      end
      TPBS_ST_FIRST_ROM:
      begin
        if (first_boot_q)
          state_d = TPBS_ST_INIT;
        else
          state_d = TPBS_ST_UNSECURE;
      end
      TPBS_ST_INIT:
      begin
        cnt_d = 16'h0000;
        if (self_rst_req)
          state_d = TPBS_ST_SELF_RST;
      end
      TPBS_ST_SELF_RST:
      begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_done)
          state_d = TPBS_ST_FIRST_ROM;
      end
      TPBS_ST_UNSECURE:
      begin
        // Serial load waits for code with no timeout at all.
        if (app_go && (mode_w != TPBS_MODE_SERIAL || serial_code_loaded))
          state_d = TPBS_ST_APP;
      end
      TPBS_ST_APP:
        state_d = TPBS_ST_APP;
      default:
        state_d = TPBS_ST_POWER_UP;
    endcase
  end

  // Read mux; secure contents read as zero outside the init phase.
  logic [7:0] rd_mux;
  assign rd_mux =
    (reg_req.addr == `TPBS_OFF_STATUS) ?
      {4'h0, first_boot_q, state_q} :
    (reg_req.addr == `TPBS_OFF_SECURE && in_init) ? secure_q :
    (reg_req.addr == `TPBS_OFF_PROC_ID && in_init) ? {4'h0, proc_id_q} :
    (reg_req.addr == `TPBS_OFF_DMA_ID && in_init) ? {4'h0, dma_id_q} :
    (reg_req.addr == `TPBS_OFF_STRAP) ? {3'h0, mode_w, strap_q} :
    8'h00;

  // Only power-on reset restores the flag and privileged IDs.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q <= TPBS_ST_POWER_UP;
      cnt_q <= 16'h0000;
      first_boot_q <= 1'b1;
      proc_id_q <= `TPBS_PROC_ID_RST;
      dma_id_q <= `TPBS_DMA_ID_RST;
      secure_q <= `TPBS_SECURE_RST;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (clr_flag)
      begin
        first_boot_q <= 1'b0;
        proc_id_q <= `TPBS_PROC_ID_APP;
        dma_id_q <= `TPBS_DMA_ID_APP;
      end
      else
      begin
        if (wr_proc)
          proc_id_q <= reg_req.wdata[3:0];
        if (wr_dma)
          dma_id_q <= reg_req.wdata[3:0];
      end
      if (wr_secure)
        secure_q <= reg_req.wdata;
    end
  end

  // Strap latch, captured once by the clock as the core leaves reset.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      strap_done_q <= 1'b0;
    end
    else if (clk_en && state_q == TPBS_ST_POWER_UP &&
             state_d == TPBS_ST_FIRST_ROM && !strap_done_q)
    begin
      strap_done_q <= 1'b1;
    end
  end

  // Data path of the latch; it has no reset and only loads once per POR.
  always_ff @(posedge core_clk)
  begin
    if (clk_en && state_q == TPBS_ST_POWER_UP &&
        state_d == TPBS_ST_FIRST_ROM && !strap_done_q)
      strap_q <= sync3_q;
  end

  // =====================================================================
  // Registered outputs.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cpu_rst <= 1'b1;
      secure_open <= 1'b0;
      run_app <= 1'b0;
      proc_master_id <= `TPBS_PROC_ID_RST;
      dma_master_id <= `TPBS_DMA_ID_RST;
      pin_map <= '0;
      boot_mode <= TPBS_MODE_FOUR_WIRE;
      strap_pin_two_out <= 1'b0;
      strap_pin_two_oe <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      cpu_rst <= (state_d == TPBS_ST_POWER_UP) ||
                 (state_d == TPBS_ST_SELF_RST);
      secure_open <= (state_d == TPBS_ST_INIT);
      run_app <= (state_d == TPBS_ST_APP);
      proc_master_id <= proc_id_q;
      dma_master_id <= dma_id_q;
      pin_map <= map_pins(mode_w);
      boot_mode <= mode_w;
      // Pin two is output only once power-up has ended, avoiding false straps.
      strap_pin_two_out <= app_pin_two_out;
      strap_pin_two_oe <= app_pin_two_oe &&
                          (state_q != TPBS_ST_POWER_UP);
      // Read data stand one cycle after the strobe, then fall to zero.
      reg_rdata <= reg_req.rd ? rd_mux : 8'h00;
    end
  end
  // Pins zero and one have no output path at all.

  // =====================================================================
  // Checks.
  AST_FLAG_SET_IN_INIT: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && state_q == TPBS_ST_FIRST_ROM && first_boot_q)
    |=> state_q == TPBS_ST_INIT)
    else $error("Init phase not entered with first-boot flag set.");
  AST_NO_SECURE_WRITE: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && reg_req.wr && !in_init &&
    reg_req.addr == `TPBS_OFF_SECURE) |=> $stable(secure_q))
    else $error("Secure write accepted outside init.");
  AST_FLAG_STAYS_CLEAR: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !first_boot_q |=> !first_boot_q)
    else $error("First-boot flag set again without power-on.");
  AST_APP_LOCKED: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == TPBS_ST_APP) |=> !secure_open)
    else $error("Secure region open in application phase.");
  AST_SECOND_BOOT: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && state_q == TPBS_ST_FIRST_ROM && !first_boot_q)
    |=> state_q == TPBS_ST_UNSECURE)
    else $error("Second boot did not take the unsecure path.");
  AST_IDS_CHANGED: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clk_en && clr_flag) |=> (proc_id_q == `TPBS_PROC_ID_APP &&
    dma_id_q == `TPBS_DMA_ID_APP))
    else $error("Master identifiers not changed at init end.");
  // The sampled reset keeps the check quiet in the release cycle.
  AST_TWO_WIRE_MAP: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (!sys_rst && clk_en && mode_w == TPBS_MODE_TWO_WIRE) |=>
    (!pin_map.debug_tdi_en && !pin_map.debug_tdo_en &&
    pin_map.debug_tms_en && pin_map.debug_tck_en))
    else $error("Two-wire mode mapped wrong pins.");
  AST_STRAP_HELD: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    strap_done_q |=> $stable(strap_q))
    else $error("Strap latch changed after release.");
  AST_RESERVED_CODE: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (!sys_rst && clk_en &&
    strap_q inside {3'h2, 3'h3, 3'h5, 3'h6, 3'h7})
    |=> boot_mode == TPBS_MODE_FOUR_WIRE)
    else $error("Reserved strap code not mapped to four-wire.");

  // Self-reset has two steps: the request, then the core held in reset.
  sequence seq_self_rst_taken;
    !sys_rst && clk_en && self_rst_req;
  endsequence
  sequence seq_core_held;
    cpu_rst && (state_q == TPBS_ST_SELF_RST);
  endsequence
  AST_SELF_RST_HOLD: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    seq_self_rst_taken |=> seq_core_held)
    else $error("Self-reset did not hold the core in reset.");
  // The pulse counter must never run past the programmed length.
  AST_SELF_RST_LEN: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == TPBS_ST_SELF_RST) |-> (cnt_q < 16'(SELF_RST_CYC)))
    else $error("Self-reset pulse ran too long.");
  AST_PIN_TWO_QUIET: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (!sys_rst && clk_en && state_q == TPBS_ST_POWER_UP) |=>
    !strap_pin_two_oe)
    else $error("Strap pin two driven during power-up.");

endmodule
`default_nettype wire

// ### tpbs_board_host.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Board straps and serial load host in front of the sequencer.
module tpbs_board_host
#(
  parameter int LOAD_CYC = 6
)
(
  input wire logic core_clk,
  input wire logic power_on,
  input wire logic [2:0] strap_code,
  input wire logic load_go,
  output logic [2:0] power_up_strap,
  output logic serial_code_loaded
);
  int load_cnt_q;

  // Straps move only while power is applied, never in mid-run.
  always @(posedge core_clk)
  begin
    if (power_on)
      power_up_strap <= strap_code;
  end

  // The loader is slow on purpose, so done comes late.
  always @(posedge core_clk)
  begin
    if (power_on || !load_go)
      load_cnt_q <= 0;
    else if (load_cnt_q < LOAD_CYC)
      load_cnt_q <= load_cnt_q + 1;
    serial_code_loaded <= load_go && (load_cnt_q == LOAD_CYC);
  end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpbs_defs.svh"

// ==========================================================
// Bench that boots the sequencer once for every strap code.
module tb_top;
  import tpbs_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [2:0] strap_code = 3'h0;
  logic load_go = 1'b0;
  logic app_pin_two_out = 1'b1;
  logic app_pin_two_oe = 1'b1;
  tpbs_req_t reg_req = '0;
  logic [2:0] power_up_strap;
  logic serial_code_loaded, cpu_rst, secure_open, run_app;
  logic pin_two_out, pin_two_oe;
  logic [7:0] reg_rdata, rd_val;
  logic [3:0] proc_id, dma_id;
  tpbs_pinmap_t pin_map;
  tpbs_mode_t boot_mode;
  logic [1:0] mode;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  // Free-running clock, 4 ns period.
  always #2 core_clk = ~core_clk;

  tpbs_sequencer #(.SAMPLE_CYC(2), .SELF_RST_CYC(4)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .power_up_strap(power_up_strap),
    .serial_code_loaded(serial_code_loaded),
    .app_pin_two_out(app_pin_two_out), .app_pin_two_oe(app_pin_two_oe),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .cpu_rst(cpu_rst),
    .proc_master_id(proc_id), .dma_master_id(dma_id),
    .secure_open(secure_open), .run_app(run_app), .pin_map(pin_map),
    .boot_mode(boot_mode), .strap_pin_two_out(pin_two_out),
    .strap_pin_two_oe(pin_two_oe));

  tpbs_board_host host (
    .core_clk(core_clk), .power_on(sys_rst), .strap_code(strap_code),
    .load_go(load_go), .power_up_strap(power_up_strap),
    .serial_code_loaded(serial_code_loaded));

  // ==========================================================
  // Shared tasks.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle right after the strobe is taken.
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Bounded wait while a signal still shows the given level.
  task automatic wait_while(input bit sel, input logic lvl);
    n = 0;
    while (((sel ? secure_open : cpu_rst) === lvl) && n < 60)
    begin
      settle(1);
      n++;
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard; a full run needs far fewer cycles.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // ==========================================================
  // Main sequence: power-up, init, self-reset, application.
  initial
  begin
    for (int s = 0; s < 8; s++)
    begin
      @(posedge core_clk);
      sys_rst <= 1'b1;
      strap_code <= 3'(s);
      load_go <= 1'b0;
      app_pin_two_out <= s[0];
      settle(4);
      chk(8'(cpu_rst), 8'h01);
      chk(8'(pin_two_oe), 8'h00);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      settle(2);
      chk(8'(pin_two_oe), 8'h00);
      wait_while(1'b1, 1'b0);
      mode = (s == `TPBS_STRAP_SERIAL) ? 2'h2 :
             (s == `TPBS_STRAP_TWO_WIRE) ? 2'h1 : 2'h0;
      chk(8'(secure_open), 8'h01);
      chk(8'(cpu_rst), 8'h00);
      chk(8'(boot_mode), 8'(mode));
      chk(8'(pin_map), (mode == 2'h2) ? 8'h1F : (mode == 2'h1) ?
          8'h06 : 8'h1E);
      reg_rd(`TPBS_OFF_STATUS, rd_val);
      chk(rd_val, 8'h0A);
      reg_rd(`TPBS_OFF_STRAP, rd_val);
      chk(rd_val, {3'h0, mode, 3'(s)});
      reg_wr(`TPBS_OFF_SECURE, 8'h5A);
      reg_rd(`TPBS_OFF_SECURE, rd_val);
      chk(rd_val, 8'h5A);
      reg_wr(`TPBS_OFF_CTRL, 8'h01);
      settle(2);
      chk(8'(proc_id), 8'h08);
      chk(8'(dma_id), 8'h09);
      reg_wr(`TPBS_OFF_CTRL, 8'h02);
      #1;
      wait_while(1'b0, 1'b0);
      wait_while(1'b0, 1'b1);
      chk(8'(n), 8'h04);
      settle(4);
      reg_rd(`TPBS_OFF_STATUS, rd_val);
      chk(rd_val, 8'h04);
      chk(8'(secure_open), 8'h00);
      reg_wr(`TPBS_OFF_SECURE, 8'hA5);
      reg_wr(`TPBS_OFF_PROC_ID, 8'h00);
      reg_rd(`TPBS_OFF_SECURE, rd_val);
      chk(rd_val, 8'h00);
      chk(8'(proc_id), 8'h08);
      reg_rd(`TPBS_OFF_PROC_ID, rd_val);
      chk(rd_val, 8'h00);
      reg_rd(4'hF, rd_val);
      chk(rd_val, 8'h00);
      // A frozen clock enable must swallow the go command.
      @(posedge core_clk);
      clk_en <= 1'b0;
      reg_wr(`TPBS_OFF_CTRL, 8'h04);
      settle(3);
      chk(8'(run_app), 8'h00);
      @(posedge core_clk);
      clk_en <= 1'b1;
      reg_wr(`TPBS_OFF_CTRL, 8'h04);
      settle(20);
      chk(8'(run_app), (mode == 2'h2) ? 8'h00 : 8'h01);
      load_go <= 1'b1;
      settle(12);
      reg_wr(`TPBS_OFF_CTRL, 8'h04);
      settle(3);
      chk(8'(run_app), 8'h01);
      chk(8'({pin_two_oe, pin_two_out}), 8'({1'b1, s[0]}));
      $display("Boot test with strap %0d finished", s);
    end
    end_sim();
  end
endmodule
`default_nettype wire
